// ==== cmf_pkg.sv ====
// Purpose: constants for the codec mixer and format control bank
// Assumes: indexes 0..8 of the indirect register space
// Notes: field positions and reset values shared by both modules
package cmf_pkg;

    localparam int unsigned NUM_REGS = 9;

    localparam logic [3:0] IDX_LEFT_ADC = 4'h0;
    localparam logic [3:0] IDX_AUX_ONE = 4'h2;
    localparam logic [3:0] IDX_AUX_TWO = 4'h4;
    localparam logic [3:0] IDX_DAC = 4'h6;
    localparam logic [3:0] IDX_RATE_FMT = 4'h8;

    localparam logic [7:0] RST_ADC = 8'h00;
    localparam logic [7:0] RST_AUX_ONE = 8'he8;
    localparam logic [7:0] RST_AUX_TWO = 8'hc8;
    localparam logic [7:0] RST_DAC = 8'h80;
    localparam logic [7:0] RST_RATE_FMT = 8'h00;

    // bits that hold state; reserved bits are never stored
    localparam logic [7:0] KEEP_ADC = 8'hef;
    localparam logic [7:0] KEEP_AUX_TWO = 8'hdf;
    localparam logic [7:0] KEEP_ALL = 8'hff;
    localparam logic [7:0] RATE_BITS = 8'h0f;
    localparam logic [7:0] FMT_BITS = 8'hf0;

    localparam int unsigned MIC_BOOST_BIT = 5;
    localparam int unsigned SRC_LSB = 6;
    localparam int unsigned AUX_BYP_BIT = 5;
    localparam int unsigned AUX_IN_MUTE_BIT = 6;
    localparam int unsigned AUX_OUT_MUTE_BIT = 7;
    localparam int unsigned DAC_MUTE_BIT = 7;
    localparam int unsigned CLK_BASE_BIT = 0;
    localparam int unsigned DIV_LSB = 1;
    localparam int unsigned STEREO_BIT = 4;
    localparam int unsigned FMT_LSB = 5;

    typedef enum logic [1:0] {
        CMF_MODE1 = 2'b00,
        CMF_MODE_RSVD = 2'b01,
        CMF_MODE3 = 2'b11,
        CMF_MODE2 = 2'b10
    } cmf_mode_t;

    localparam logic [1:0] SRC_LINE = 2'h0;
    localparam logic [1:0] SRC_AUX_ONE = 2'h1;
    localparam logic [1:0] SRC_MIC = 2'h2;
    localparam logic [1:0] SRC_LOOPBACK = 2'h3;

    localparam logic [2:0] FMT_U8 = 3'h0;
    localparam logic [2:0] FMT_MULAW = 3'h1;
    localparam logic [2:0] FMT_LE16 = 3'h2;
    localparam logic [2:0] FMT_ALAW = 3'h3;
    localparam logic [2:0] FMT_RSVD_A = 3'h4;
    localparam logic [2:0] FMT_ADPCM = 3'h5;
    localparam logic [2:0] FMT_BE16 = 3'h6;
    localparam logic [2:0] FMT_RSVD_B = 3'h7;

    localparam logic [2:0] DIV_CODE_NA_A = 3'h4;
    localparam logic [2:0] DIV_CODE_NA_B = 3'h5;

    function automatic logic [11:0] cmf_rate_div(input logic [2:0] c);
        case (c)
            3'h0: cmf_rate_div = 12'd3072;
            3'h1: cmf_rate_div = 12'd1536;
            3'h2: cmf_rate_div = 12'd896;
            3'h3: cmf_rate_div = 12'd768;
            3'h4: cmf_rate_div = 12'd448;
            3'h5: cmf_rate_div = 12'd384;
            3'h6: cmf_rate_div = 12'd512;
            default: cmf_rate_div = 12'd2560;
        endcase
    endfunction : cmf_rate_div

endpackage : cmf_pkg

// ==== cmf_chan.sv ====
// Purpose: one channel's effective mixer controls
// Assumes: mode and feature inputs come from same-clock logic
// Notes: outputs registered, one cycle behind the register bank
`timescale 1ns/100ps
module cmf_chan import cmf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [1:0] i_mode,
    input wire logic i_feature,
    input wire logic [7:0] i_adc_ctrl,
    input wire logic [7:0] i_aux_one,
    input wire logic [7:0] i_aux_two,
    input wire logic [7:0] i_dac,
    output logic [3:0] o_adc_gain,
    output logic o_mic_boost,
    output logic o_input_mux_mode,
    output logic [1:0] o_adc_source,
    output logic o_loopback,
    output logic [4:0] o_aux_one_gain,
    output logic o_aux_one_bypass_mute,
    output logic o_aux_one_in_mute,
    output logic o_aux_one_out_mute,
    output logic [4:0] o_aux_two_gain,
    output logic o_aux_two_in_mute,
    output logic o_aux_two_out_mute,
    output logic [6:0] o_master_volume,
    output logic o_master_mute,
    output logic [5:0] o_bus_wave_atten,
    output logic o_bus_wave_mute
);

    logic m3;
    logic [1:0] src;
    logic [31:0] nx_d;
    logic [31:0] nx_q;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        m3 = (i_mode == CMF_MODE3);
        src = i_adc_ctrl[SRC_LSB +: 2];
        nx_d = '0;
        nx_d[3:0] = i_adc_ctrl[3:0];
        nx_d[4] = !m3 && i_adc_ctrl[MIC_BOOST_BIT];
        nx_d[5] = !m3;
        nx_d[7:6] = src;
        nx_d[8] = (src == SRC_LOOPBACK);
        nx_d[13:9] = i_aux_one[4:0];
        // modes 1/2: bypass opens only when aux one is the source
        nx_d[14] = m3 ? i_aux_one[AUX_BYP_BIT]
                      : (src != SRC_AUX_ONE);
        nx_d[15] = !m3 || i_aux_one[AUX_IN_MUTE_BIT];
        nx_d[16] = i_aux_one[AUX_OUT_MUTE_BIT];
        nx_d[21:17] = i_aux_two[4:0];
        nx_d[22] = !m3 || i_aux_two[AUX_IN_MUTE_BIT];
        nx_d[23] = i_aux_two[AUX_OUT_MUTE_BIT];
        if (!i_feature) begin
            nx_d[30:24] = i_dac[6:0];
            nx_d[31] = i_dac[DAC_MUTE_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nx_q <= '0;
            o_bus_wave_atten <= '0;
            o_bus_wave_mute <= 1'b0;
        end else begin
            nx_q <= nx_d;
            // bit 6 is reserved in this reading and ignored
            o_bus_wave_atten <= i_feature ? i_dac[5:0] : '0;
            o_bus_wave_mute <= i_feature && i_dac[DAC_MUTE_BIT];
        end
    end

    assign o_adc_gain = nx_q[3:0];
    assign o_mic_boost = nx_q[4];
    assign o_input_mux_mode = nx_q[5];
    assign o_adc_source = nx_q[7:6];
    assign o_loopback = nx_q[8];
    assign o_aux_one_gain = nx_q[13:9];
    assign o_aux_one_bypass_mute = nx_q[14];
    assign o_aux_one_in_mute = nx_q[15];
    assign o_aux_one_out_mute = nx_q[16];
    assign o_aux_two_gain = nx_q[21:17];
    assign o_aux_two_in_mute = nx_q[22];
    assign o_aux_two_out_mute = nx_q[23];
    assign o_master_volume = nx_q[30:24];
    assign o_master_mute = nx_q[31];

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    chk_mic_mode_three: assert property (
        i_mode == CMF_MODE3 |=> !o_mic_boost)
        else $error("mic boost active in mode 3");
    chk_in_mute_forced: assert property (
        i_mode != CMF_MODE3 |=> o_aux_one_in_mute && o_aux_two_in_mute)
        else $error("input mixer aux path not muted");
    chk_loopback_sel: assert property (
        ##1 o_loopback == ($past(i_adc_ctrl[7:6]) == SRC_LOOPBACK))
        else $error("loopback does not follow source select");
    chk_master_mute: assert property (
        !i_feature && i_dac[7] |=> o_master_mute && !o_bus_wave_mute)
        else $error("master mute not applied");
    chk_bus_wave: assert property (
        i_feature |=> o_bus_wave_atten == $past(i_dac[5:0])
            && o_bus_wave_mute == $past(i_dac[7]) && !o_master_mute)
        else $error("bus wave controls wrong");

endmodule : cmf_chan

// ==== cmf_regs.sv ====
// Purpose: indirect registers 0..8, mixer and rate/format control
// Assumes: index, strobes and mode inputs are same-clock logic
// Notes: index register and host bus decode live outside
`timescale 1ns/100ps

module cmf_regs import cmf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [3:0] i_index,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [1:0] i_codec_mode,
    input wire logic i_mode_change_enable,
    input wire logic i_playback_mode_change_enable,
    input wire logic i_interface_feature_enable,
    input wire logic i_wavetable_enable,
    input wire logic i_alt_rate_enable,
    input wire logic i_interface_rate_override,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic [1:0][3:0] o_adc_gain,
    output logic [1:0] o_mic_boost,
    output logic [1:0] o_input_mux_mode,
    output logic [1:0][1:0] o_adc_source,
    output logic [1:0] o_loopback,
    output logic [1:0][4:0] o_aux_one_gain,
    output logic [1:0] o_aux_one_bypass_mute,
    output logic [1:0] o_aux_one_in_mute,
    output logic [1:0] o_aux_one_out_mute,
    output logic [1:0][4:0] o_aux_two_gain,
    output logic [1:0] o_aux_two_in_mute,
    output logic [1:0] o_aux_two_out_mute,
    output logic [1:0][6:0] o_master_volume,
    output logic [1:0] o_master_mute,
    output logic [1:0][5:0] o_bus_wave_atten,
    output logic [1:0] o_bus_wave_mute,
    output logic o_clock_base_select,
    output logic [2:0] o_rate_divide_select,
    output logic [11:0] o_rate_divider,
    output logic o_rate_code_valid,
    output logic o_rate_from_regs,
    output logic o_play_stereo,
    output logic o_capture_follows_play,
    output logic [2:0] o_data_format,
    output logic o_data_format_valid
);

    ////////////////////////////////////////////////////////////////////
    // register masks per index

    function automatic logic [7:0] keep_mask(input logic [3:0] idx);
        case (idx)
            4'h0, 4'h1: keep_mask = KEEP_ADC;
            4'h4, 4'h5: keep_mask = KEEP_AUX_TWO;
            4'h2, 4'h3, 4'h6, 4'h7, 4'h8: keep_mask = KEEP_ALL;
            default: keep_mask = 8'h00;
        endcase
    endfunction : keep_mask

    function automatic logic [7:0] reset_val(input logic [3:0] idx);
        case (idx)
            4'h2, 4'h3: reset_val = RST_AUX_ONE;
            4'h4, 4'h5: reset_val = RST_AUX_TWO;
            4'h6, 4'h7: reset_val = RST_DAC;
            4'h8: reset_val = RST_RATE_FMT;
            default: reset_val = RST_ADC;
        endcase
    endfunction : reset_val

    ////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register file and host access

    logic [7:0] regs_q [0:NUM_REGS-1];
    logic [7:0] regs_d [0:NUM_REGS-1];
    logic [7:0] wmask;
    logic [7:0] rdata_d;
    logic in_range;
    logic mode_change_enable;
    logic fmt_open;

    always_comb begin
        regs_d = regs_q;
        rdata_d = 8'h00;
        mode_change_enable = i_mode_change_enable;
        fmt_open = mode_change_enable || i_playback_mode_change_enable;
        in_range = (i_index <= IDX_RATE_FMT);
        wmask = keep_mask(i_index);
        if (i_index == IDX_RATE_FMT) begin
            // rate bits need full mode change; format also via playback
            if (!mode_change_enable)
                wmask = wmask & ~RATE_BITS;
            if (!fmt_open)
                wmask = wmask & ~FMT_BITS;
        end
        if (i_data_wr && in_range) begin
            regs_d[i_index] = (regs_q[i_index] & ~wmask)
                            | (i_wdata & wmask);
        end
        // reserved bits are not stored and read back as zero
        if (in_range)
            rdata_d = regs_q[i_index];
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= reset_val(4'(i)) & keep_mask(4'(i));
            end
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
        end else begin
            regs_q <= regs_d;
            if (i_data_rd)
                o_rdata <= rdata_d;
            o_rdata_valid <= i_data_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-channel mixer decode, index 0 is left

    logic feature_on;

    assign feature_on = i_interface_feature_enable || i_wavetable_enable;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        cmf_chan u_chan (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(rst_n_q),
            .i_mode(i_codec_mode),
            .i_feature(feature_on),
            .i_adc_ctrl(regs_q[IDX_LEFT_ADC + 4'(ch)]),
            .i_aux_one(regs_q[IDX_AUX_ONE + 4'(ch)]),
            .i_aux_two(regs_q[IDX_AUX_TWO + 4'(ch)]),
            .i_dac(regs_q[IDX_DAC + 4'(ch)]),
            .o_adc_gain(o_adc_gain[ch]),
            .o_mic_boost(o_mic_boost[ch]),
            .o_input_mux_mode(o_input_mux_mode[ch]),
            .o_adc_source(o_adc_source[ch]),
            .o_loopback(o_loopback[ch]),
            .o_aux_one_gain(o_aux_one_gain[ch]),
            .o_aux_one_bypass_mute(o_aux_one_bypass_mute[ch]),
            .o_aux_one_in_mute(o_aux_one_in_mute[ch]),
            .o_aux_one_out_mute(o_aux_one_out_mute[ch]),
            .o_aux_two_gain(o_aux_two_gain[ch]),
            .o_aux_two_in_mute(o_aux_two_in_mute[ch]),
            .o_aux_two_out_mute(o_aux_two_out_mute[ch]),
            .o_master_volume(o_master_volume[ch]),
            .o_master_mute(o_master_mute[ch]),
            .o_bus_wave_atten(o_bus_wave_atten[ch]),
            .o_bus_wave_mute(o_bus_wave_mute[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // rate and format decode

    logic [7:0] rf;
    logic [2:0] div_code;
    logic [2:0] fmt_d;
    logic base_d;
    logic rate_ok_d;
    logic mode_one;

    always_comb begin
        rf = regs_q[IDX_RATE_FMT];
        mode_one = (i_codec_mode == CMF_MODE1);
        base_d = rf[CLK_BASE_BIT];
        div_code = rf[DIV_LSB +: 3];
        // first clock base cannot make the two fastest codes
        rate_ok_d = base_d || ((div_code != DIV_CODE_NA_A)
                    && (div_code != DIV_CODE_NA_B));
        fmt_d = rf[FMT_LSB +: 3];
        if (mode_one)
            fmt_d[2] = 1'b0;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_clock_base_select <= 1'b0;
            o_rate_divide_select <= 3'h0;
            o_rate_divider <= 12'd3072;
            o_rate_code_valid <= 1'b1;
            o_rate_from_regs <= 1'b1;
            o_play_stereo <= 1'b0;
            o_capture_follows_play <= 1'b1;
            o_data_format <= FMT_U8;
            o_data_format_valid <= 1'b1;
        end else begin
            o_clock_base_select <= base_d;
            o_rate_divide_select <= div_code;
            o_rate_divider <= cmf_rate_div(div_code);
            o_rate_code_valid <= rate_ok_d;
            // alternate rate logic owns the rate when either is set
            o_rate_from_regs <= !(i_alt_rate_enable
                               || i_interface_rate_override);
            // stereo: L then R; mono: copy to both, capture left only
            o_play_stereo <= rf[STEREO_BIT];
            o_capture_follows_play <= mode_one;
            o_data_format <= fmt_d;
            o_data_format_valid <= (fmt_d != FMT_RSVD_A)
                                && (fmt_d != FMT_RSVD_B);
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_q);

    logic wr8;
    assign wr8 = i_data_wr && (i_index == IDX_RATE_FMT);

    chk_rate_locked: assert property (
        wr8 && !i_mode_change_enable
        |=> regs_q[8][3:0] == $past(regs_q[8][3:0]))
        else $error("rate bits changed without mode change enable");
    chk_fmt_locked: assert property (
        wr8 && !i_mode_change_enable && !i_playback_mode_change_enable
        |=> regs_q[8][7:4] == $past(regs_q[8][7:4]))
        else $error("format bits changed while locked");
    chk_fmt_open: assert property (
        wr8 && i_mode_change_enable |=> regs_q[8] == $past(i_wdata))
        else $error("unlocked write to rate register lost");
    chk_rate_div: assert property (
        wr8 && i_mode_change_enable
        |-> ##2 o_rate_divider == cmf_rate_div($past(i_wdata[3:1], 2)))
        else $error("divider does not match divide code");
    chk_fmt_mode_one: assert property (
        i_codec_mode == CMF_MODE1 |=> !o_data_format[2])
        else $error("format high bit not forced in mode 1");
    chk_rate_override: assert property (
        i_alt_rate_enable |=> !o_rate_from_regs)
        else $error("rate override ignored");
    chk_rsvd_zero: assert property (
        i_data_wr && i_index == 4'h0 |=> !regs_q[0][4])
        else $error("reserved bit stored");
    chk_read_back: assert property (
        i_data_rd && i_index == 4'h6
        |=> o_rdata_valid && o_rdata == $past(regs_q[6]))
        else $error("read data wrong");

    cov_rate_write: cover property (wr8 && i_mode_change_enable);
    cov_mode_three: cover property (i_codec_mode == CMF_MODE3
                                    && o_loopback[0]);
    cov_feature_on: cover property (feature_on ##1 o_bus_wave_mute[1]);
    cov_playback_fmt: cover property (wr8 && !i_mode_change_enable
                                      && i_playback_mode_change_enable);

endmodule : cmf_regs

// ==== cmf_host.sv ====
// Purpose: host model doing indexed register access
// Assumes: strobes move on the falling edge of i_clk_sys
// Notes: reserved bits are cleared before each write
`timescale 1ns/100ps
module cmf_host import cmf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    input wire logic i_rdata_valid,
    output logic [3:0] o_index,
    output logic o_data_wr,
    output logic o_data_rd,
    output logic [7:0] o_wdata
);
    initial begin
        o_index = 4'hf;
        o_data_wr = 1'b0;
        o_data_rd = 1'b0;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_index = a;
        o_wdata = d & ((a < 4'h2) ? KEEP_ADC :
            (a == 4'h4 || a == 4'h5) ? KEEP_AUX_TWO : KEEP_ALL);
        o_data_wr = 1'b1;
        @(negedge i_clk_sys);
        o_data_wr = 1'b0;
        // released bus shows no stale value
        o_wdata = ~o_wdata;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d,
        output logic v);
        @(negedge i_clk_sys);
        o_index = a;
        o_data_rd = 1'b1;
        @(negedge i_clk_sys);
        o_data_rd = 1'b0;
        d = i_rdata;
        v = i_rdata_valid;
    endtask : rd
endmodule : cmf_host

// ==== cmf_regs_test.sv ====
// Purpose: self-checking bench for the mixer and format bank
// Assumes: inputs move on the falling edge of i_clk_sys
// Notes: every register access goes through the host model
`timescale 1ns/100ps
module cmf_regs_test;
    logic i_clk_sys = 1'b0;
    logic i_reset_n, i_data_wr, i_data_rd, o_rdata_valid;
    logic [3:0] i_index;
    logic [7:0] i_wdata, o_rdata;
    logic [1:0] i_codec_mode;
    logic i_mode_change_enable, i_playback_mode_change_enable;
    logic i_interface_feature_enable, i_wavetable_enable;
    logic i_alt_rate_enable, i_interface_rate_override;
    logic [1:0][3:0] o_adc_gain;
    logic [1:0][1:0] o_adc_source;
    logic [1:0][4:0] o_aux_one_gain, o_aux_two_gain;
    logic [1:0][6:0] o_master_volume;
    logic [1:0][5:0] o_bus_wave_atten;
    logic [1:0] o_mic_boost, o_input_mux_mode, o_loopback;
    logic [1:0] o_aux_one_bypass_mute, o_aux_one_in_mute;
    logic [1:0] o_aux_one_out_mute, o_aux_two_in_mute;
    logic [1:0] o_aux_two_out_mute, o_master_mute, o_bus_wave_mute;
    logic o_clock_base_select, o_rate_code_valid, o_rate_from_regs;
    logic o_play_stereo, o_capture_follows_play, o_data_format_valid;
    logic [2:0] o_rate_divide_select, o_data_format;
    logic [11:0] o_rate_divider;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [11:0] divs [8] = '{12'd3072, 12'd1536, 12'd896, 12'd768,
        12'd448, 12'd384, 12'd512, 12'd2560};
    logic [7:0] row_wr [9] = '{8'hff, 8'h5a, 8'h37, 8'hc1, 8'hff,
        8'h2a, 8'h7f, 8'hb3, 8'hff};
    logic [7:0] row_rd [9] = '{8'hef, 8'h4a, 8'h37, 8'hc1, 8'hdf,
        8'h0a, 8'h7f, 8'hb3, 8'hff};
    logic [7:0] rst_rd [9] = '{8'h00, 8'h00, 8'he8, 8'he8, 8'hc8,
        8'hc8, 8'h80, 8'h80, 8'h00};

    cmf_regs i_cmf_regs (.i_clk_sys, .i_reset_n, .i_index, .i_data_wr,
        .i_data_rd, .i_wdata, .i_codec_mode, .i_mode_change_enable,
        .i_playback_mode_change_enable, .i_interface_feature_enable,
        .i_wavetable_enable, .i_alt_rate_enable, .i_interface_rate_override,
        .o_rdata, .o_rdata_valid, .o_adc_gain, .o_mic_boost,
        .o_input_mux_mode, .o_adc_source, .o_loopback, .o_aux_one_gain,
        .o_aux_one_bypass_mute, .o_aux_one_in_mute, .o_aux_one_out_mute,
        .o_aux_two_gain, .o_aux_two_in_mute, .o_aux_two_out_mute,
        .o_master_volume, .o_master_mute, .o_bus_wave_atten,
        .o_bus_wave_mute, .o_clock_base_select, .o_rate_divide_select,
        .o_rate_divider, .o_rate_code_valid, .o_rate_from_regs,
        .o_play_stereo, .o_capture_follows_play, .o_data_format,
        .o_data_format_valid);
    cmf_host i_cmf_host (.i_clk_sys, .i_rdata(o_rdata),
        .i_rdata_valid(o_rdata_valid), .o_index(i_index),
        .o_data_wr(i_data_wr), .o_data_rd(i_data_rd), .o_wdata(i_wdata));

    always #10 i_clk_sys = ~i_clk_sys;
    // the whole run needs well under a thousand cycles
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] g,
        input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic gap;
        repeat (2) @(negedge i_clk_sys);
    endtask : gap
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        i_cmf_host.wr(a, d);
        gap();
    endtask : put
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_cmf_host.rd(a, d, v);
        chk("rdata", d, e);
        chk("rdata_valid", v, 1'b1);
    endtask : rchk
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial begin
        i_reset_n = 1'b0;
        i_codec_mode = 2'b11;
        i_mode_change_enable = 1'b1;
        i_playback_mode_change_enable = 1'b0;
        i_interface_feature_enable = 1'b0;
        i_wavetable_enable = 1'b0;
        i_alt_rate_enable = 1'b0;
        i_interface_rate_override = 1'b0;
        repeat (12) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk("divider", o_rate_divider, 12'd3072);
        for (int k = 0; k < 9; k++) begin
            put(k[3:0], row_wr[k]);
            rchk(k[3:0], row_rd[k]);
        end
        chk("right_gain", o_adc_gain[1], 4'ha);
        put(4'h0, 8'he5);
        put(4'h2, 8'h68);
        put(4'h4, 8'h88);
        chk("mode3", {o_mic_boost[0], o_loopback[0], o_input_mux_mode[0],
            o_aux_one_in_mute[0], o_aux_one_bypass_mute[0],
            o_aux_two_in_mute[0], o_aux_one_out_mute[0],
            o_aux_two_out_mute[0], o_adc_gain[0]}, 12'h595);
        chk("aux_gain", {o_aux_one_gain[0], o_aux_two_gain[0]},
            10'h108);
        i_codec_mode = 2'b10;
        gap();
        chk("mode2", {o_mic_boost[0], o_loopback[0], o_input_mux_mode[0],
            o_aux_one_in_mute[0], o_aux_one_bypass_mute[0],
            o_aux_two_in_mute[0], o_aux_one_out_mute[0],
            o_aux_two_out_mute[0], o_adc_gain[0]}, 12'hfd5);
        put(4'h0, 8'h65);
        chk("aux_src", {o_adc_source[0], o_loopback[0],
            o_aux_one_bypass_mute[0]}, 4'h4);
        put(4'h6, 8'hc5);
        for (int f = 0; f < 3; f++) begin
            {i_interface_feature_enable, i_wavetable_enable} = f[1:0];
            gap();
            chk("dac", {o_master_mute[0], o_master_volume[0],
                o_bus_wave_mute[0], o_bus_wave_atten[0]},
                (f == 0) ? 16'h6280 : 16'h0045);
        end
        for (int c = 0; c < 16; c++) begin
            put(4'h8, {4'h0, c[2:0], c[3]});
            chk("divider", o_rate_divider, divs[c[2:0]]);
            chk("code_ok", o_rate_code_valid,
                !(!c[3] && c[2:1] == 2'b10));
            chk("rate_sel", {o_clock_base_select, o_rate_divide_select},
                c[3:0]);
            chk("mono", o_play_stereo, 1'b0);
        end
        for (int f = 0; f < 8; f++) begin
            put(4'h8, {f[2:0], 5'h13});
            chk("format", {o_data_format, o_data_format_valid,
                o_play_stereo, o_capture_follows_play},
                {f[2:0], f != 4 && f != 7, 2'b10});
        end
        i_codec_mode = 2'b00;
        put(4'h8, 8'hf0);
        chk("mode1_fmt", {o_data_format, o_data_format_valid,
            o_play_stereo, o_capture_follows_play}, 6'h1f);
        i_codec_mode = 2'b11;
        put(4'h8, 8'h00);
        i_mode_change_enable = 1'b0;
        put(4'h8, 8'hff);
        rchk(4'h8, 8'h00);
        i_playback_mode_change_enable = 1'b1;
        put(4'h8, 8'hff);
        rchk(4'h8, 8'hf0);
        i_mode_change_enable = 1'b1;
        i_playback_mode_change_enable = 1'b0;
        for (int f = 0; f < 4; f++) begin
            {i_alt_rate_enable, i_interface_rate_override} = f[1:0];
            gap();
            chk("rate_src", o_rate_from_regs, f == 0);
        end
        put(4'h9, 8'h5a);
        rchk(4'h9, 8'h00);
        rchk(4'h8, 8'hf0);
        i_reset_n = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        for (int k = 0; k < 9; k++)
            rchk(k[3:0], rst_rd[k]);
        close_out();
    end
endmodule : cmf_regs_test
